// File: mis_sequencer.sv
// Microcoded instruction sequencer: prefetch pipeline, instruction flows, restart
`timescale 1ns/1ps
module mis_sequencer
  import mis_pkg::*;
(
  input wire logic clock, // 200 MHz microcycle clock
  input wire logic arst_n, // Asynchronous reset, active low
  input wire logic [15:0] read_data, // Memory or port read data
  input wire logic cond_pass, // Condition test result
  input wire logic [15:0] branch_index_register, // Branch index value
  input wire logic [15:0] port_index_register, // Port index value
  input wire logic [15:0] operand_data, // Operand from memory for indexed ops
  input wire logic [11:0] port_pulse_count, // Port strobe width count N
  output mis_bus_t bus, // Bus request and address
  output mis_strobe_t strobes, // Port strobes and peripheral reset
  output logic [15:0] data_out, // Data output register
  output logic [15:0] program_counter, // Program counter
  output logic [15:0] first_operand_register, // First operand register
  output logic [15:0] low_prefetch_register, // Low prefetch register
  output logic [15:0] second_prefetch_register, // Second prefetch / instruction
  output logic [8:0] micro_address, // Current microprogram location
  output logic exec_pulse // One cycle per executed macroinstruction, except a conditional branch whose test fails
);

  mis_state_t state;
  mis_state_t next_state;
  logic [11:0] loop_counter;
  logic [15:0] transfer_register;
  logic [15:0] stack_pointer;
  logic [15:0] alu_r0;
  logic [15:0] au_r4;
  logic [15:0] au_r5;
  logic [2:0] init_step;
  logic [1:0] fill_count;

  // Decode and address formation
  wire [3:0] opcode = second_prefetch_register[15:12];
  wire [15:0] branch_target = low_prefetch_register + branch_index_register;
  wire [15:0] port_address = low_prefetch_register + port_index_register;
  wire [15:0] pc_plus2 = program_counter + MIS_STEP2;
  wire [15:0] pc_plus6 = program_counter + MIS_STEP6;
  wire [15:0] xfer_plus2 = transfer_register + MIS_STEP2;
  wire ctr_expired = (loop_counter == MIS_CTR_STOP);
  // Shift loop leaves on the pass that takes the counter to minus one, so the
  // body runs count+1 times; an all-ones count is caught too so it cannot hang
  wire ctr_last = (loop_counter == 12'h000) || ctr_expired;
  wire pipe_full = (fill_count == 2'd3);
  // Six init steps, 0 to 5; the last one releases the peripheral reset
  wire init_done = (init_step == 3'd5);
  // Step shown on the location output is the one the next cycle executes
  wire [2:0] next_init_step = (state == MIS_S_INIT) ? init_step + 3'd1 : 3'd0;

  // Next-state selection; mapping only reaches the low microprogram area
  always_comb begin
    next_state = state;
    case (state)
      MIS_S_RESTART: next_state = MIS_S_INIT;
      MIS_S_INIT: next_state = init_done ? MIS_S_START : MIS_S_INIT;
      MIS_S_START: next_state = MIS_S_SECOND_STARTUP_STEP;
      MIS_S_SECOND_STARTUP_STEP: next_state = MIS_S_THIRD_STARTUP_STEP;
      MIS_S_THIRD_STARTUP_STEP: next_state = MIS_S_DECODE;
      MIS_S_DECODE: begin
        case (opcode)
          MIS_OP_RX: next_state = MIS_S_RX_ADDR;
          MIS_OP_IMM: next_state = MIS_S_THIRD_STARTUP_STEP;
          MIS_OP_BR: next_state = MIS_S_BR1;
          MIS_OP_BAL: next_state = MIS_S_BR1;
          MIS_OP_BC: next_state = MIS_S_BC1;
          MIS_OP_SHF: next_state = MIS_S_SHF1;
          MIS_OP_IN: next_state = MIS_S_IN1;
          MIS_OP_OUT: next_state = MIS_S_OUT1;
          default: next_state = MIS_S_DECODE;
        endcase
      end
      MIS_S_RX_ADDR: next_state = MIS_S_OPERAND_FETCH_SUBROUTINE;
      MIS_S_OPERAND_FETCH_SUBROUTINE: next_state = MIS_S_RX_EXEC;
      MIS_S_RX_EXEC: next_state = MIS_S_DECODE;
      MIS_S_BC1: next_state = cond_pass ? MIS_S_BR1 : MIS_S_THIRD_STARTUP_STEP;
      MIS_S_BR1: next_state = (opcode == MIS_OP_BAL) ? MIS_S_BAL2 : MIS_S_BR2;
      MIS_S_BAL2: next_state = MIS_S_BR2;
      MIS_S_BR2: next_state = MIS_S_THIRD_STARTUP_STEP;
      MIS_S_SHF1: next_state = MIS_S_SHF2;
      MIS_S_SHF2: next_state = ctr_last ? MIS_S_SHF3 : MIS_S_SHF2;
      MIS_S_SHF3: next_state = MIS_S_DECODE;
      MIS_S_IN1: next_state = MIS_S_IN2;
      MIS_S_IN2: next_state = ctr_expired ? MIS_S_IN3 : MIS_S_IN2;
      MIS_S_IN3: next_state = MIS_S_IN4;
      MIS_S_IN4: next_state = MIS_S_SECOND_STARTUP_STEP;
      MIS_S_OUT1: next_state = MIS_S_OUT3;
      MIS_S_OUT3: next_state = ctr_expired ? MIS_S_OUT4 : MIS_S_OUT3;
      MIS_S_OUT4: next_state = MIS_S_START;
      default: next_state = MIS_S_RESTART;
    endcase
  end

  // State and microprogram location
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state <= MIS_S_RESTART;
      micro_address <= MIS_RESTART_LOC;
    end else begin
      state <= next_state;
      if (next_state == MIS_S_INIT) begin
        micro_address <= MIS_INIT_LOC + {6'h00, next_init_step};
      end else begin
        micro_address <= MIS_RESTART_LOC;
      end
    end
  end

  // Initialization sequence: one action per step, reset released last
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      init_step <= 3'd0;
      alu_r0 <= 16'hFFFF;
      stack_pointer <= 16'hFFFF;
      au_r4 <= 16'h0000;
      au_r5 <= 16'h0000;
    end else if (state == MIS_S_RESTART) begin
      init_step <= 3'd0;
    end else if (state == MIS_S_INIT) begin
      init_step <= init_step + 3'd1;
      case (init_step)
        3'd0: alu_r0 <= 16'h0000;
        3'd2: stack_pointer <= 16'h0000;
        3'd3: au_r4 <= MIS_AU_R4_INIT;
        3'd4: au_r5 <= MIS_AU_R5_INIT;
        default: ;
      endcase
    end
  end

  // Loop counter: loaded by first shift or port step, counts down to minus one
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      loop_counter <= MIS_CTR_STOP;
    end else if (state == MIS_S_SHF1) begin
      loop_counter <= second_prefetch_register[11:0];
    end else if (state == MIS_S_IN1 || state == MIS_S_OUT1) begin
      loop_counter <= port_pulse_count;
    end else if (!ctr_expired) begin
      loop_counter <= loop_counter - 12'd1;
    end
  end

  // Pipeline fill tracking; the fourth startup microinstruction sees it full
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      fill_count <= 2'd0;
    end else if (state == MIS_S_START) begin
      fill_count <= 2'd1;
    end else if ((state == MIS_S_SECOND_STARTUP_STEP || state == MIS_S_THIRD_STARTUP_STEP) && !pipe_full) begin
      fill_count <= fill_count + 2'd1;
    end
  end

  // Bus request and address: memory pipeline or held port address
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      bus <= '0;
    end else begin
      bus.bus_request <= (state != MIS_S_INIT) && (state != MIS_S_RESTART);
      case (state)
        MIS_S_BR1: bus.address <= branch_target;
        MIS_S_BR2: bus.address <= xfer_plus2;
        MIS_S_IN1: bus.address <= port_address;
        MIS_S_OUT1: bus.address <= port_address;
        MIS_S_IN2, MIS_S_IN3, MIS_S_OUT3: bus.address <= bus.address;
        MIS_S_DECODE, MIS_S_RX_EXEC, MIS_S_SHF3: bus.address <= pc_plus6;
        default: bus.address <= program_counter;
      endcase
    end
  end

  // Port strobes and peripheral reset, all in one process so the output
  // struct has a single driver; read and write last N+2 cycles each
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      strobes.port_read <= 1'b0;
      strobes.port_write <= 1'b0;
      strobes.periph_reset <= 1'b0;
    end else begin
      if (state == MIS_S_RESTART) begin
        strobes.periph_reset <= 1'b1;
      end else if (state == MIS_S_INIT && init_done) begin
        strobes.periph_reset <= 1'b0; // Last init step
      end
      if (state == MIS_S_IN1) begin
        strobes.port_read <= 1'b1;
      end else if (state == MIS_S_IN2 && ctr_expired) begin
        strobes.port_read <= 1'b0;
      end
      if (state == MIS_S_OUT1) begin
        strobes.port_write <= 1'b1;
      end else if (state == MIS_S_OUT3 && ctr_expired) begin
        strobes.port_write <= 1'b0; // Peripheral latches here
      end
    end
  end

  // Datapath registers: PC, prefetch, transfer, operand and data out
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      program_counter <= 16'h0000;
      low_prefetch_register <= 16'h0000;
      second_prefetch_register <= 16'h0000;
      transfer_register <= 16'h0000;
      first_operand_register <= 16'h0000;
      data_out <= 16'h0000;
      exec_pulse <= 1'b0;
    end else begin
      exec_pulse <= 1'b0;
      case (state)
        MIS_S_INIT: if (init_step == 3'd1) program_counter <= 16'h0000;
        MIS_S_START, MIS_S_SECOND_STARTUP_STEP, MIS_S_THIRD_STARTUP_STEP: begin
          second_prefetch_register <= low_prefetch_register;
          low_prefetch_register <= read_data;
          program_counter <= pc_plus2;
        end
        MIS_S_DECODE: if (opcode == MIS_OP_RR || opcode == MIS_OP_IMM) begin
          second_prefetch_register <= low_prefetch_register; // PC+2
          low_prefetch_register <= read_data; // PC+4
          program_counter <= pc_plus2;
          exec_pulse <= 1'b1;
        end
        MIS_S_RX_EXEC: begin
          first_operand_register <= operand_data;
          exec_pulse <= 1'b1;
        end
        MIS_S_BR1: transfer_register <= branch_target;
        MIS_S_BAL2: first_operand_register <= program_counter;
        MIS_S_BR2: begin
          program_counter <= xfer_plus2;
          low_prefetch_register <= read_data;
          exec_pulse <= 1'b1;
        end
        MIS_S_BC1: low_prefetch_register <= read_data;
        MIS_S_SHF1: second_prefetch_register <= low_prefetch_register;
        MIS_S_SHF3: begin
          low_prefetch_register <= read_data;
          exec_pulse <= 1'b1;
        end
        // Port data is only valid while the strobe is up: take it on the
        // edge that drops the strobe, not a cycle later
        MIS_S_IN2: if (ctr_expired) low_prefetch_register <= read_data;
        MIS_S_IN4: begin
          first_operand_register <= low_prefetch_register;
          exec_pulse <= 1'b1;
        end
        MIS_S_OUT1: data_out <= first_operand_register;
        MIS_S_OUT4: exec_pulse <= 1'b1;
        default: ;
      endcase
    end
  end

endmodule

// File: mis_pkg.sv
// Package for the microcoded instruction sequencer: constants, states and carriers
package mis_pkg;

  // Microprogram locations
  localparam logic [8:0] MIS_RESTART_LOC = 9'h000;
  localparam logic [8:0] MIS_INIT_LOC = 9'h180;
  localparam logic [8:0] MIS_INIT_END_LOC = 9'h185;
  localparam int MIS_MAP_SPAN = 256;

  // Address increments for the prefetch pipeline
  localparam logic [15:0] MIS_STEP2 = 16'h0002;
  localparam logic [15:0] MIS_STEP4 = 16'h0004;
  localparam logic [15:0] MIS_STEP6 = 16'h0006;

  // Reset values for address-unit registers four and five
  localparam logic [15:0] MIS_AU_R4_INIT = 16'h0002;
  localparam logic [15:0] MIS_AU_R5_INIT = 16'h0004;

  // Loop counter stop value (minus one)
  localparam logic [11:0] MIS_CTR_STOP = 12'hFFF;

  // Opcode classes (upper bits of the fetched instruction word)
  localparam logic [3:0] MIS_OP_RR = 4'h1;
  localparam logic [3:0] MIS_OP_RX = 4'h2;
  localparam logic [3:0] MIS_OP_IMM = 4'h3;
  localparam logic [3:0] MIS_OP_BR = 4'h4;
  localparam logic [3:0] MIS_OP_BC = 4'h5;
  localparam logic [3:0] MIS_OP_BAL = 4'h6;
  localparam logic [3:0] MIS_OP_SHF = 4'h7;
  localparam logic [3:0] MIS_OP_IN = 4'h8;
  localparam logic [3:0] MIS_OP_OUT = 4'h9;

  // Sequencer states, one-hot
  typedef enum logic [22:0] {
    MIS_S_RESTART = 23'h000001,
    MIS_S_INIT = 23'h000002,
    MIS_S_START = 23'h000004,
    MIS_S_SECOND_STARTUP_STEP = 23'h000008,
    MIS_S_THIRD_STARTUP_STEP = 23'h000010,
    MIS_S_DECODE = 23'h000020,
    MIS_S_RX_ADDR = 23'h000040,
    MIS_S_OPERAND_FETCH_SUBROUTINE = 23'h000080,
    MIS_S_RX_EXEC = 23'h000100,
    MIS_S_BR1 = 23'h000200,
    MIS_S_BR2 = 23'h000400,
    MIS_S_BAL2 = 23'h000800,
    MIS_S_BC1 = 23'h001000,
    MIS_S_SHF2 = 23'h002000,
    MIS_S_SHF3 = 23'h004000,
    MIS_S_IN2 = 23'h008000,
    MIS_S_IN3 = 23'h010000,
    MIS_S_IN4 = 23'h020000,
    MIS_S_OUT3 = 23'h040000,
    MIS_S_OUT4 = 23'h080000,
    MIS_S_SHF1 = 23'h100000,
    MIS_S_IN1 = 23'h200000,
    MIS_S_OUT1 = 23'h400000
  } mis_state_t;

  // Port strobe group toward I/O peripherals
  typedef struct packed {
    logic port_read;
    logic port_write;
    logic periph_reset;
  } mis_strobe_t;

  // Bus request group toward memory
  typedef struct packed {
    logic bus_request;
    logic [15:0] address;
  } mis_bus_t;

endpackage

// File: mis_sequencer_properties.sv
// Port-level assertion checker for the microcoded instruction sequencer
`timescale 1ns/1ps
module mis_properties
  import mis_pkg::*;
(
  input wire logic clock, // Microcycle clock
  input wire logic arst_n, // Async reset, active low
  input wire logic [11:0] port_pulse_count, // Strobe width count
  input wire mis_bus_t bus, // Bus request and address
  input wire mis_strobe_t strobes, // Port strobes
  input wire logic [15:0] data_out, // Data output register
  input wire logic [15:0] first_operand_register, // First operand
  input wire logic [8:0] micro_address // Microprogram location
);
  logic [12:0] rd_len;
  logic [12:0] wr_len;
  wire [12:0] want_len = {1'b0, port_pulse_count} + 13'h0002;
  // High-time counters: a long pulse cannot be unrolled as a repetition
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rd_len <= 13'h0000;
      wr_len <= 13'h0000;
    end else begin
      rd_len <= strobes.port_read ? rd_len + 13'h0001 : 13'h0000;
      wr_len <= strobes.port_write ? wr_len + 13'h0001 : 13'h0000;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  AST_READ_WIDTH: assert property ($fell(strobes.port_read) |-> rd_len == want_len)
    else $error("read strobe width wrong");
  AST_WRITE_WIDTH: assert property ($fell(strobes.port_write) |-> wr_len == want_len)
    else $error("write strobe width wrong");
  AST_READ_HOLD: assert property (strobes.port_read && $past(strobes.port_read)
    |-> bus.bus_request && $stable(bus.address)) else $error("port address moved");
  AST_READ_TAIL: assert property ($fell(strobes.port_read) |-> $stable(bus.address))
    else $error("address dropped with read strobe");
  AST_WRITE_DATA: assert property (strobes.port_write |-> data_out == first_operand_register)
    else $error("output data not from operand");
  AST_RESTART: assert property ($rose(strobes.periph_reset) |-> ##[0:1] micro_address == 9'h180)
    else $error("restart did not reach init");
  AST_INIT_RST: assert property (micro_address inside {[9'h180:9'h184]} |-> strobes.periph_reset)
    else $error("peripheral reset low during init");
  AST_INIT_DONE: assert property (micro_address == 9'h185 |-> ##[1:2] !strobes.periph_reset)
    else $error("peripheral reset not released");
endmodule

bind mis_sequencer mis_properties u_props (.clock(clock), .arst_n(arst_n),
  .port_pulse_count(port_pulse_count), .bus(bus), .strobes(strobes), .data_out(data_out),
  .first_operand_register(first_operand_register), .micro_address(micro_address));

// File: mis_port_model.sv
// Far-side model: uniform memory words and one I/O port on the system bus
`timescale 1ns/1ps
module mis_port_model
  import mis_pkg::*;
(
  input wire logic clock, // Microcycle clock
  input wire logic arst_n, // Async reset, active low
  input wire mis_bus_t bus, // Bus request and address
  input wire mis_strobe_t strobes, // Port strobes
  input wire logic [15:0] data_out, // Data toward the port
  input wire logic [15:0] fill_word, // Word every memory place returns
  input wire logic [15:0] port_value, // Value the input port presents
  output logic [15:0] read_data, // Data bus toward the sequencer
  output logic [15:0] latched // Word taken by the output port
);
  logic [15:0] last;
  logic write_q;
  // Port data stays valid while the read strobe is up; an idle bus shows the
  // inverse of its last word so a stale value never passes for a fresh one
  assign read_data = strobes.port_read ? port_value : (bus.bus_request ? fill_word : ~last);
  // Output port latches on the trailing edge of the write strobe
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      last <= 16'h0000;
      write_q <= 1'b0;
      latched <= 16'h0000;
    end else begin
      last <= read_data;
      write_q <= strobes.port_write;
      if (write_q && !strobes.port_write) latched <= data_out;
    end
  end
endmodule

// File: mis_sequencer_bench.sv
// Self-checking bench for the microcoded instruction sequencer
`timescale 1ns/1ps
module mis_sequencer_bench;
  import mis_pkg::*;
  localparam logic [15:0] PORT_VAL = 16'hA5C3;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic cond_pass = 1'b0;
  logic [15:0] bix = 16'h0000;
  logic [15:0] pix = 16'h0010;
  logic [15:0] opnd = 16'h1234;
  logic [11:0] pcount = 12'h003;
  logic [15:0] fill = 16'h8000;
  logic [15:0] read_data, data_out, pc, r1, lpf, spf, latched, a;
  logic [8:0] maddr;
  logic exec_pulse;
  mis_bus_t bus;
  mis_strobe_t strobes;
  int fail_count = 0;
  int checks_done = 0;
  int cycles = 0;
  int n;

  mis_sequencer u_dut (.clock(clock), .arst_n(arst_n), .read_data(read_data),
    .cond_pass(cond_pass), .branch_index_register(bix), .port_index_register(pix),
    .operand_data(opnd), .port_pulse_count(pcount), .bus(bus), .strobes(strobes),
    .data_out(data_out), .program_counter(pc), .first_operand_register(r1),
    .low_prefetch_register(lpf), .second_prefetch_register(spf), .micro_address(maddr),
    .exec_pulse(exec_pulse));
  mis_port_model u_far (.clock(clock), .arst_n(arst_n), .bus(bus), .strobes(strobes),
    .data_out(data_out), .fill_word(fill), .port_value(PORT_VAL), .read_data(read_data),
    .latched(latched));

  initial begin
    forever #2.5 clock = ~clock;
  end

  // Hang guard, far above the few hundred cycles the scenarios need
  always @(posedge clock) begin
    cycles++;
    if (cycles == 4000) begin
      fail_count++;
      summarize();
    end
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Inputs move and outputs are read 1 ns after the edge
  task automatic tick();
    @(posedge clock);
    #1;
  endtask

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Restart reaches initialization, which steps in order under peripheral reset
  task automatic t_init();
    for (n = 0; n < 50 && maddr !== 9'h180; n++) tick();
    check({15'h0000, strobes.periph_reset}, 16'h0001);
    for (n = 1; n < 6; n++) begin
      tick();
      check({7'h00, maddr}, 16'h0180 + n[15:0]);
    end
    repeat (2) tick();
    check({15'h0000, strobes.periph_reset}, 16'h0000);
  endtask

  // Port input: strobe of N+2 cycles, then port data reaches the operand register
  task automatic t_input();
    for (n = 0; n < 300 && strobes.port_read !== 1'b1; n++) tick();
    for (n = 0; n < 300 && strobes.port_read === 1'b1; n++) tick();
    check(n[15:0], 16'h0005);
    repeat (4) tick();
    check(r1, PORT_VAL);
  endtask

  // Port output: same width, port latches the operand when the strobe drops
  task automatic t_output();
    fill = 16'h9000;
    for (n = 0; n < 300 && strobes.port_write !== 1'b1; n++) tick();
    for (n = 0; n < 300 && strobes.port_write === 1'b1; n++) tick();
    check(n[15:0], 16'h0005);
    tick();
    check(latched, PORT_VAL);
  endtask

  // Branch: target is low prefetch plus index, then target+2 is requested
  task automatic t_branch();
    fill = 16'h4000;
    bix = 16'h0100;
    for (n = 0; n < 300 && bus.address !== 16'h4100; n++) tick();
    check({15'h0000, bus.bus_request}, 16'h0001);
    check(bus.address, 16'h4100);
    for (n = 0; n < 3 && bus.address !== 16'h4102; n++) tick();
    check(bus.address, 16'h4102);
  endtask

  // Cycles from one executed instruction to the next, memory holding one word
  task automatic gap(input logic [15:0] word, output int k);
    fill = word;
    repeat (40) tick();
    for (k = 0; k < 50 && exec_pulse !== 1'b1; k++) tick();
    tick();
    for (k = 1; k < 50 && exec_pulse !== 1'b1; k++) tick();
  endtask

  // Immediate: executes at decode, refills from the third startup step
  task automatic t_imm();
    gap(16'h3000, n);
    check(n[15:0], 16'h0002);
  endtask

  // Shift count 2: step one, three shift passes, then the request step
  task automatic t_shift();
    gap(16'h7002, n);
    check(n[15:0], 16'h0006);
  endtask

  // Conditional branch with the test passing runs the branch routine
  task automatic t_cond();
    cond_pass = 1'b1;
    gap(16'h5000, n);
    check(n[15:0], 16'h0005);
  endtask

  // Branch-and-link: one extra step that saves PC (target+4) as operand
  task automatic t_link();
    gap(16'h6000, n);
    check(n[15:0], 16'h0005);
    check(r1, 16'h6104);
  endtask

  // Indexed: form address, fetch operand, execute; last, as it never refills
  task automatic t_indexed();
    gap(16'h2000, n);
    check(n[15:0], 16'h0004);
    check(r1, opnd);
  endtask

  // Register stream: one instruction per cycle, fetch address steps by two
  task automatic t_stream();
    fill = 16'h1000;
    repeat (30) tick();
    a = bus.address;
    for (n = 0; n < 4; n++) begin
      tick();
      check({15'h0000, exec_pulse}, 16'h0001);
      check(bus.address, a + MIS_STEP2);
      a = bus.address;
    end
  endtask

  initial begin
    repeat (6) @(posedge clock);
    #1 arst_n = 1'b1;
    t_init();
    t_input();
    t_output();
    t_branch();
    t_stream();
    t_imm();
    t_shift();
    t_cond();
    t_link();
    t_indexed();
    summarize();
  end
endmodule
